//--- design/sop_consts.svh
// offsets, field positions and reset values of the logic array block
`ifndef SOP_CONSTS_SVH
`define SOP_CONSTS_SVH

// ----------------------------------------------------------------
// register word offsets (avalon word addresses)
// ----------------------------------------------------------------
`define SOP_OFS_TERM_BASE 8'h00
`define SOP_OFS_TERM_END  8'h8f
`define SOP_OFS_POL       8'h90
`define SOP_OFS_MODE      8'h91
`define SOP_OFS_STAT      8'h92
`define SOP_OFS_PINS      8'h93

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SOP_TERM_HALF_BIT 0
`define SOP_PINS_DED_LSB  8
`define SOP_OE_TERM_IDX   8

// ----------------------------------------------------------------
// reset values (erased state)
// ----------------------------------------------------------------
`define SOP_POL_RST       8'hff
`define SOP_MODE_RST      8'h00
`define SOP_WAIT_RST      1'b1
`define SOP_OE_N_RST      1'b1

`endif

//--- design/sop_pkg.sv
// types shared by the logic array block and its macrocells
package sop_pkg;

    // ------------------------------------------------------------
    // per-macrocell output control configuration
    // ------------------------------------------------------------
    typedef struct packed {
        logic invert;       // invert the sum before the output stage
        logic registered;   // feedback from register, else from pin
    } sop_mc_cfg_t;

    // ------------------------------------------------------------
    // pin drive pair of one macrocell
    // ------------------------------------------------------------
    typedef struct packed {
        logic level;        // value offered to the pin
        logic oe_n;         // low while the pin is driven
    } sop_drive_t;

endpackage

//--- design/sop_macrocell.sv
// one macrocell: eight summed terms, enable term, register, feedback
`include "sop_consts.svh"

module sop_macrocell
    import sop_pkg::*;
#(
    parameter int COLS = 36
)(
    // clock and reset
    input  wire logic            ref_clk_in,
    input  wire logic            rst_n_in,
    // array columns and stored connections
    input  wire logic [COLS-1:0] cols_in,
    input  wire logic [COLS-1:0] conn_in [9],
    input  wire sop_mc_cfg_t     cfg_in,
    // synchronised pin level
    input  wire logic            pin_sync_in,
    // results
    output sop_drive_t           drive_out,
    output logic                 fb_out
);

    // ------------------------------------------------------------
    // product terms and sum
    // ------------------------------------------------------------
    logic [8:0] term;      // every product term, index 8 is the enable
    logic       sum_raw;   // fixed or of the eight summed terms
    logic       sum_pol;   // sum after the optional inversion
    logic       d_reg;     // macrocell storage element
    logic       oe_n_reg;  // registered pin enable, low drives

    // even column of each pair is the true form of that signal
    localparam logic [COLS-1:0] PAIR_MASK = {(COLS/2){2'b01}};

    // a term holding both forms of one signal is constantly false
    always_comb begin
        sum_raw = 1'b0;
        for (int j = 0; j < 9; j++) begin
            term[j] = &(~conn_in[j] | cols_in);
        end
        for (int j = 0; j < 8; j++) begin
            sum_raw = sum_raw | term[j];
        end
        sum_pol = sum_raw ^ cfg_in.invert;
    end

    // ------------------------------------------------------------
    // d flip-flop, low after reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            d_reg <= 1'b0;
        end else begin
            d_reg <= sum_pol;
        end
    end

    // enable term steers the pin driver
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            oe_n_reg <= `SOP_OE_N_RST;
        end else begin
            oe_n_reg <= ~term[`SOP_OE_TERM_IDX];
        end
    end

    // feedback picks register or pin, never both
    assign fb_out = cfg_in.registered ? d_reg : pin_sync_in;
    assign drive_out.level = d_reg;
    assign drive_out.oe_n  = oe_n_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    fb_from_reg_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        cfg_in.registered |-> fb_out == d_reg
    ) else $error("feedback not from register");

    fb_from_pin_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !cfg_in.registered |-> fb_out == pin_sync_in
    ) else $error("feedback not from pin");

    enable_follow_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        term[`SOP_OE_TERM_IDX] |=> !drive_out.oe_n
    ) else $error("enable term did not drive pin");

    dont_care_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (|(conn_in[0][COLS-1:1] & conn_in[0][COLS-2:0]
           & PAIR_MASK[COLS-2:0])) |-> !term[0]
    ) else $error("contradictory term not removed");

    pol_capture_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        1'b1 |=> d_reg == ($past(sum_raw) ^ $past(cfg_in.invert))
    ) else $error("register missed inverted sum");

endmodule

//--- design/sop_logic_array.sv
// sum-of-products logic array with eight macrocells, avalon config
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`include "sop_consts.svh"

module sop_logic_array
    import sop_pkg::*;
#(
    parameter int NUM_IN = 10,  // dedicated inputs, 10 or 14
    parameter int NUM_MC = 8    // macrocells and i/o pins
)(
    // clock and reset
    input  wire logic              ref_clk_in,
    input  wire logic              rst_n_in,
    // avalon-mm slave
    input  wire logic [7:0]        avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic      [31:0]       avs_readdata_out,
    output logic                   avs_waitrequest_out,
    // dedicated input pins
    input  wire logic [NUM_IN-1:0] ded_pin_in,
    // i/o pins as input, output and active-low enable
    input  wire logic [NUM_MC-1:0] io_pin_in,
    output logic      [NUM_MC-1:0] io_pin_out,
    output logic      [NUM_MC-1:0] io_pin_oe_n_out
);

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NSIG  = NUM_IN + NUM_MC;  // array signals
    localparam int COLS  = 2 * NSIG;         // true and complement
    localparam int HIW   = COLS - 32;        // bits in upper word
    localparam int TPM   = 9;                // terms per macrocell
    localparam int NTERM = TPM * NUM_MC;     // all product terms

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [COLS-1:0]   term_mem [NTERM];  // connection per column
    logic [NUM_MC-1:0] pol_reg;           // invert mask
    logic [NUM_MC-1:0] mode_reg;          // registered mask
    logic              wait_reg;          // waitrequest flop
    logic [31:0]       rdata_reg;         // read data flop

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [NUM_IN-1:0] ded_meta_reg;  // first stage, read by second only
    logic [NUM_IN-1:0] ded_sync_reg;  // safe dedicated levels
    logic [NUM_MC-1:0] io_meta_reg;   // first stage, read by second only
    logic [NUM_MC-1:0] io_sync_reg;   // safe pin levels

    // ------------------------------------------------------------
    // array signals
    // ------------------------------------------------------------
    logic [NUM_MC-1:0] fb;          // feedback from each macrocell
    logic [NSIG-1:0]   sig;         // dedicated then feedback
    logic [COLS-1:0]   cols;        // even true, odd complement
    sop_drive_t        drv [NUM_MC]; // pin drive per macrocell
    logic [NUM_MC-1:0] q_vec;       // register values for status

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic        req;        // any request pending
    logic        done;       // request completes at this edge
    logic        hit_term;   // address falls in the term window
    logic [6:0]  term_idx;   // term addressed
    logic        term_hi;    // upper half of the term
    logic [31:0] bmask;      // byte enables as a bit mask
    logic [31:0] rd_mux;     // read value before the flop

    // the term window ends at word 0x8f; above it sits a small
    // register file, so one compare splits the two address spaces
    assign req      = avs_read_in | avs_write_in;
    assign done     = req & ~wait_reg;
    assign term_idx = avs_address_in[7:1];
    assign term_hi  = avs_address_in[`SOP_TERM_HALF_BIT];
    assign hit_term = (avs_address_in <= `SOP_OFS_TERM_END)
                    && (int'(term_idx) < NTERM);

    // expand byte enables to a bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            bmask[8*b +: 8] = {8{avs_byteenable_in[b]}};
        end
    end

    // ------------------------------------------------------------
    // synchronise pins: two flops before any logic
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            ded_meta_reg <= '0;
            ded_sync_reg <= '0;
        end else begin
            ded_meta_reg <= ded_pin_in;
            ded_sync_reg <= ded_meta_reg;
        end
    end

    // unused pins should be tied; a floating pin only wobbles the
    // synchronised copy, never the array directly
    // the pin level, driven or not, returns here
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            io_meta_reg <= '0;
            io_sync_reg <= '0;
        end else begin
            io_meta_reg <= io_pin_in;
            io_sync_reg <= io_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // column build: each signal gives true and complement
    // ------------------------------------------------------------
    assign sig = {fb, ded_sync_reg};

    for (genvar s = 0; s < NSIG; s++) begin : g_col
        assign cols[2*s]   = sig[s];
        assign cols[2*s+1] = ~sig[s];
    end

    // ------------------------------------------------------------
    // waitrequest: one wait state on every access
    // ------------------------------------------------------------
    // fixed latency keeps the slave simple; the master stalls one cycle per access
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wait_reg <= `SOP_WAIT_RST;
        end else begin
            wait_reg <= ~(req & wait_reg);
        end
    end

    // ------------------------------------------------------------
    // term memory: erased connects all, writes break links
    // ------------------------------------------------------------
    // writes may also restore links, which erasure alone could do
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            for (int t = 0; t < NTERM; t++) begin
                term_mem[t] <= '1;
            end
        end else if (done && avs_write_in && hit_term) begin
            if (term_hi) begin
                term_mem[term_idx][COLS-1:32] <=
                    (term_mem[term_idx][COLS-1:32] & ~bmask[HIW-1:0])
                  | (avs_writedata_in[HIW-1:0] & bmask[HIW-1:0]);
            end else begin
                term_mem[term_idx][31:0] <=
                    (term_mem[term_idx][31:0] & ~bmask)
                  | (avs_writedata_in & bmask);
            end
        end
    end

    // ------------------------------------------------------------
    // polarity register: set bit inverts the sum
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pol_reg <= `SOP_POL_RST;
        end else if (done && avs_write_in
                     && avs_address_in == `SOP_OFS_POL
                     && avs_byteenable_in[0]) begin
            pol_reg <= avs_writedata_in[NUM_MC-1:0];
        end
    end

    // ------------------------------------------------------------
    // mode register: set bit selects registered feedback
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            mode_reg <= `SOP_MODE_RST;
        end else if (done && avs_write_in
                     && avs_address_in == `SOP_OFS_MODE
                     && avs_byteenable_in[0]) begin
            mode_reg <= avs_writedata_in[NUM_MC-1:0];
        end
    end

    // ------------------------------------------------------------
    // read mux: unmapped addresses read zero
    // ------------------------------------------------------------
    // reads have no side effect, so the mux needs no hold logic
    always_comb begin
        rd_mux = '0;
        if (hit_term) begin
            if (term_hi) begin
                rd_mux[HIW-1:0] = term_mem[term_idx][COLS-1:32];
            end else begin
                rd_mux = term_mem[term_idx][31:0];
            end
        end else begin
            unique case (avs_address_in)
                `SOP_OFS_POL:  rd_mux[NUM_MC-1:0] = pol_reg;
                `SOP_OFS_MODE: rd_mux[NUM_MC-1:0] = mode_reg;
                `SOP_OFS_STAT: rd_mux[NUM_MC-1:0] = q_vec;
                `SOP_OFS_PINS: begin
                    rd_mux[NUM_MC-1:0] = io_sync_reg;
                    rd_mux[`SOP_PINS_DED_LSB +: NUM_IN] = ded_sync_reg;
                end
                default:       rd_mux = '0;
            endcase
        end
    end

    // read data is loaded as the wait state ends
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            rdata_reg <= '0;
        end else if (avs_read_in && wait_reg) begin
            rdata_reg <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // macrocells, one per i/o pin
    // ------------------------------------------------------------
    // every macrocell sees every column, its own feedback included;
    // a registered loop therefore closes within one clock
    for (genvar m = 0; m < NUM_MC; m++) begin : g_mc
        logic [COLS-1:0] conn [TPM];  // this macrocell's terms
        sop_mc_cfg_t     cfg;         // output control bits

        // gather the nine terms of this macrocell
        always_comb begin
            for (int j = 0; j < TPM; j++) begin
                conn[j] = term_mem[m*TPM + j];
            end
        end

        assign cfg.invert     = pol_reg[m];
        assign cfg.registered = mode_reg[m];

        sop_macrocell #(
            .COLS        (COLS)
        ) u_mc (
            .ref_clk_in  (ref_clk_in),
            .rst_n_in    (rst_n_in),
            .cols_in     (cols),
            .conn_in     (conn),
            .cfg_in      (cfg),
            .pin_sync_in (io_sync_reg[m]),
            .drive_out   (drv[m]),
            .fb_out      (fb[m])
        );

        // pin mode is set purely by the enable term
        assign io_pin_out[m]      = drv[m].level;
        assign io_pin_oe_n_out[m] = drv[m].oe_n;
        assign q_vec[m]           = drv[m].level;
    end

    // ------------------------------------------------------------
    // bus outputs
    // ------------------------------------------------------------
    assign avs_waitrequest_out = wait_reg;
    assign avs_readdata_out    = rdata_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // these watch the bus side and the erased state; the array
    // itself is checked inside each macrocell
    regs_low_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> q_vec == '0
    ) else $error("registers not low after reset");

    erased_cfg_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> pol_reg == '1 && mode_reg == '0
    ) else $error("erased configuration wrong");

    erased_off_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> io_pin_oe_n_out == '1
    ) else $error("erased pins are driven");

    wait_once_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        req && wait_reg |=> !avs_waitrequest_out ##1 avs_waitrequest_out
    ) else $error("waitrequest not one cycle");

    mode_write_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        done && avs_write_in && avs_address_in == `SOP_OFS_MODE
        && avs_byteenable_in[0]
        |=> mode_reg == $past(avs_writedata_in[NUM_MC-1:0])
    ) else $error("mode write lost");

    stat_read_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        avs_read_in && wait_reg && avs_address_in == `SOP_OFS_STAT
        |=> avs_readdata_out[NUM_MC-1:0] == $past(q_vec)
    ) else $error("status read wrong");

    pol_write_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        done && avs_write_in && avs_address_in == `SOP_OFS_POL
        && avs_byteenable_in[0]
        |=> pol_reg == $past(avs_writedata_in[NUM_MC-1:0])
    ) else $error("polarity write lost");

    term_write_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        done && avs_write_in && hit_term && !term_hi
        && avs_byteenable_in == 4'hf
        |=> term_mem[$past(term_idx)][31:0] == $past(avs_writedata_in)
    ) else $error("term write lost");

    term_read_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        avs_read_in && wait_reg && hit_term && !term_hi
        |=> avs_readdata_out == $past(term_mem[term_idx][31:0])
    ) else $error("term read wrong");

    wait_idle_a: assert property (
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !req |=> avs_waitrequest_out
    ) else $error("waitrequest low without request");

endmodule

//--- test/sop_board_model.sv
// board around the logic array: drives dedicated inputs, resolves i/o pins
module sop_board_model #(
    parameter int NUM_IN = 10,  // dedicated inputs
    parameter int NUM_MC = 8    // i/o pins
)(
    // requests from the bench
    input  wire logic [NUM_IN-1:0] ded_val_in,
    input  wire logic [NUM_MC-1:0] io_val_in,
    input  wire logic [NUM_MC-1:0] io_en_in,
    // what the array offers to its pins
    input  wire logic [NUM_MC-1:0] dev_level_in,
    input  wire logic [NUM_MC-1:0] dev_oe_n_in,
    // resolved wires
    output logic      [NUM_IN-1:0] ded_pin_out,
    output logic      [NUM_MC-1:0] io_level_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // dedicated pins are plain board drivers
    // ------------------------------------------------------------
    assign ded_pin_out = ded_val_in;

    // ------------------------------------------------------------
    // wire level per i/o pin; pull-up when nobody drives
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_MC; i++) begin
            if (!dev_oe_n_in[i]) begin
                // two drivers on one wire read as unknown
                io_level_out[i] = io_en_in[i] ? 1'bx : dev_level_in[i];
            end else begin
                // pin used as input or left floating
                io_level_out[i] = io_en_in[i] ? io_val_in[i] : 1'b1;
            end
        end
    end
endmodule

//--- test/sop_logic_array_test.sv
// self-checking bench for the sum-of-products logic array
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
    miscompares++; $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
    end end
module sop_logic_array_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk, rst_n;              // clock and reset
    logic [7:0]  addr;                    // bus address
    logic        rd, wr;                  // bus strobes
    logic [31:0] wdata, rdata;            // bus data
    logic        waitreq;                 // bus wait
    logic [9:0]  ded_val, ded_pin;        // dedicated pins
    logic [7:0]  io_val, io_en, io_lvl;   // board side of i/o pins
    logic [7:0]  pin_out, pin_oe_n;       // array side of i/o pins
    int          miscompares, num_checks; // counters
    logic [31:0] rv;                      // last read value
    // ------------------------------------------------------------
    // design and board
    // ------------------------------------------------------------
    sop_logic_array #(.NUM_IN(10), .NUM_MC(8)) DUT (
        .ref_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .ded_pin_in(ded_pin),
        .io_pin_in(io_lvl), .io_pin_out(pin_out),
        .io_pin_oe_n_out(pin_oe_n));
    sop_board_model #(.NUM_IN(10), .NUM_MC(8)) board (
        .ded_val_in(ded_val), .io_val_in(io_val), .io_en_in(io_en),
        .dev_level_in(pin_out), .dev_oe_n_in(pin_oe_n),
        .ded_pin_out(ded_pin), .io_level_out(io_lvl));
    // ------------------------------------------------------------
    // clock
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ------------------------------------------------------------
    // verdict, the one place the run ends
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // one bus transfer; the request is held until the rising edge at
    // which waitrequest is sampled low, read data is taken there
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        if (waitreq !== 1'b0) begin
            miscompares++;
            complete_run();
        end
        rv = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // term t: columns 31:0 at word 2t, 35:32 at word 2t+1
    task automatic set_term(input int t, input logic [35:0] c);
        bus(1'b1, 8'(2 * t), c[31:0]);
        bus(1'b1, 8'(2 * t + 1), {28'h0, c[35:32]});
    endtask
    // let syncs and output flops settle
    task automatic settle;
        repeat (6) @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_state;
        `CHK("oe_n", 8'hff, pin_oe_n)
        `CHK("pin_out", 8'h00, pin_out)
        bus(1'b0, 8'h90, 32'h0);
        `CHK("polarity", 32'h0000_00ff, rv)
        bus(1'b0, 8'h91, 32'h0);
        `CHK("mode", 32'h0000_0000, rv)
        bus(1'b0, 8'h92, 32'h0);
        `CHK("status", 32'h0000_00ff, rv)
        bus(1'b0, 8'h00, 32'h0);
        `CHK("term lo", 32'hffff_ffff, rv)
        bus(1'b0, 8'h8f, 32'h0);
        `CHK("term hi", 32'h0000_000f, rv)
        bus(1'b1, 8'h94, 32'hffff_ffff);
        bus(1'b0, 8'h94, 32'h0);
        `CHK("unmapped", 32'h0000_0000, rv)
    endtask
    // mc0 = ded0 | !ded2, a killed term on ded4, enabled by ded1
    task automatic t_comb_logic;
        logic e;
        set_term(0, 36'h0_0000_0001);
        set_term(1, 36'h0_0000_0020);
        set_term(2, 36'h0_0000_0300);
        // unused terms hold both forms of ded0; an empty term is true
        for (int t = 3; t < 8; t++) begin
            set_term(t, 36'h0_0000_0003);
        end
        set_term(8, 36'h0_0000_0004);
        for (int p = 0; p < 2; p++) begin
            bus(1'b1, 8'h90, {24'h0, 7'h7f, p[0]});
            for (int i = 0; i < 8; i++) begin
                @(posedge clk);
                ded_val <= {5'h0, i[2], 1'b0, i[1], 1'b1, i[0]};
                e = (i[0] | !i[1]) ^ p[0];
                settle();
                `CHK("sum out", e, pin_out[0])
                `CHK("driven", 1'b0, pin_oe_n[0])
            end
        end
        @(posedge clk);
        ded_val <= 10'h000;
        settle();
        `CHK("released", 1'b1, pin_oe_n[0])
    endtask
    // mc1 registered, term = !feedback1: halves the clock
    task automatic t_registered;
        logic prev;
        set_term(9, 36'h0_0080_0000);
        for (int t = 10; t < 17; t++) begin
            set_term(t, 36'h0_0000_0003);
        end
        set_term(17, 36'h0_0000_0004);
        bus(1'b1, 8'h90, 32'h0000_00fc);
        bus(1'b1, 8'h91, 32'h0000_0002);
        ded_val <= 10'h002;
        settle();
        `CHK("reg driven", 1'b0, pin_oe_n[1])
        prev = pin_out[1];
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            `CHK("toggle", !prev, pin_out[1])
            prev = pin_out[1];
        end
    endtask
    // mc2 as input only, mc3 follows mc2's pin
    task automatic t_pin_feedback;
        set_term(27, 36'h0_0100_0000);
        for (int t = 28; t < 35; t++) begin
            set_term(t, 36'h0_0000_0003);
        end
        set_term(35, 36'h0_0000_0004);
        bus(1'b1, 8'h90, 32'h0000_00f4);
        io_en <= 8'h04;
        for (int v = 0; v < 2; v++) begin
            io_val <= {5'h0, v[0], 2'h0};
            settle();
            `CHK("input only", 1'b1, pin_oe_n[2])
            `CHK("pin fb", v[0], pin_out[3])
            bus(1'b0, 8'h93, 32'h0);
            `CHK("pins reg", v[0], rv[2])
        end
    endtask
    // reset while mc1 toggles: registers come back low
    task automatic t_reset_again;
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK("pins after", 8'h00, pin_out)
        `CHK("oe after", 8'hff, pin_oe_n)
        bus(1'b0, 8'h91, 32'h0);
        `CHK("mode after", 32'h0000_0000, rv)
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        miscompares = 0;
        num_checks  = 0;
        rst_n   = 1'b0;
        addr    = 8'h00;
        rd      = 1'b0;
        wr      = 1'b0;
        wdata   = 32'h0;
        ded_val = 10'h000;
        io_val  = 8'h00;
        io_en   = 8'h00;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset_state();
        t_comb_logic();
        t_registered();
        t_pin_feedback();
        t_reset_again();
        complete_run();
    end
endmodule
